//--- hw/acc_register_transfer_decode.sv
// Decoder and executor for the accumulator-to-register transfer instructions
//
// Behaviour
// - 0x00E loads second register from acc
// - 0x2A8/0x2A9 write LCD control one/two
// - 0x029 loads pointer from acc bits 2..0
// - 0x01A extension register = second:acc
// - 0x217 writes interrupt control one
// - 0x21B/0x214/0x215 write key wakeup regs
// - LCD mode copies; two/three at 0x20B/0x20C
// - 0x20D loads LCD timer and its reload
// - RAM store at pointer, file XOR j
// - 0x216 writes clock mode select
// - 0x2AA writes only acc bit 0
// - 0x235 loads prescaler and reload pair
// - 0x22D/0x22E write pull-up controls
// - 0x23F loads first timer reload
`timescale 1ns/1ps
module acc_register_transfer_decode
  import acc_xfer_pkg::*;
#(
  parameter int RAM_ADDR_W = 9  // Full RAM address width: bank, file, pointer
) (
  input  wire logic                  clk_sys,          // Instruction clock, 50 MHz
  input  wire logic                  rst_n,            // Async reset, active low
  input  wire logic                  insn_valid,       // Instruction word present
  input  wire logic [INSN_W-1:0]     insn,             // Fetched instruction word
  input  wire logic [NIB_W-1:0]      acc_in,           // Accumulator from core
  input  wire logic [BANK_W-1:0]     bank_in,          // RAM bank register
  input  wire logic [NIB_W-1:0]      file_in,          // RAM file register from core
  input  wire logic                  carry_in,         // Carry flag from core
  output logic                       acc_we,           // Accumulator write strobe
  output logic [NIB_W-1:0]           acc_wdata,        // New accumulator value
  output logic                       file_we,          // File register write strobe
  output logic [NIB_W-1:0]           file_wdata,       // New file register value
  output logic                       carry_out,        // Carry kept as is
  output logic                       skip_next,        // Never asserted by this group
  output logic                       ram_we,           // RAM write strobe
  output logic [RAM_ADDR_W-1:0]      ram_addr,         // RAM word address
  output logic [NIB_W-1:0]           ram_wdata,        // RAM write data
  output logic                       hit,              // Word belongs to this group
  output logic [NIB_W-1:0]           second_reg_r,     // Second working register
  output logic [PTR_W-1:0]           ram_pointer_r,    // RAM pointer
  output logic [BYTE_W-1:0]          extension_r,      // Extension register
  output logic [NIB_W-1:0]           lcd_ctrl_one_r,   // LCD control one
  output logic [NIB_W-1:0]           lcd_ctrl_two_r,   // LCD control two
  output logic [NIB_W-1:0]           port_drive_cfg_0_r, // Port drive config 0
  output logic [NIB_W-1:0]           port_drive_cfg_1_r, // Port drive config 1
  output logic [NIB_W-1:0]           port_drive_cfg_2_r, // Port drive config 2
  output logic [NIB_W-1:0]           irq_ctrl_one_r,   // Interrupt control one
  output logic [NIB_W-1:0]           key_wake_0_r,     // Key wakeup 0
  output logic [NIB_W-1:0]           key_wake_1_r,     // Key wakeup 1
  output logic [NIB_W-1:0]           key_wake_2_r,     // Key wakeup 2
  output logic [NIB_W-1:0]           lcd_mode_one_r,   // LCD mode one
  output logic [NIB_W-1:0]           lcd_mode_two_r,   // LCD mode two
  output logic [NIB_W-1:0]           lcd_mode_three_r, // LCD mode three
  output logic [NIB_W-1:0]           lcd_timer_r,      // LCD clock timer counter
  output logic [NIB_W-1:0]           counter_reload_value_r, // LCD timer reload
  output logic [NIB_W-1:0]           clock_mode_sel_r, // Clock mode select
  output logic                       timer_gate_r,     // One-bit timer gate
  output logic [BYTE_W-1:0]          prescale_count_r, // Prescaler counter
  output logic [BYTE_W-1:0]          prescale_reload_r, // Prescaler reload
  output logic [NIB_W-1:0]           pullup_ctrl_0_r,  // Pull-up control 0
  output logic [NIB_W-1:0]           pullup_ctrl_1_r,  // Pull-up control 1
  output logic [BYTE_W-1:0]          first_reload_r    // First timer reload
);

  // Opcode decode, each gated by a valid word
  // A word with valid low is never decoded, whatever the idle bus shows
  wire logic d_bank    = insn_valid && insn == OP_COPY_BANK_TO_ACC;
  wire logic d_second  = insn_valid && insn == OP_COPY_ACC_TO_SECOND;
  // LCD control pair, one register each
  wire logic d_lc1     = insn_valid && insn == OP_WRITE_LCD_CTRL_ONE;
  wire logic d_lc2     = insn_valid && insn == OP_WRITE_LCD_CTRL_TWO;
  wire logic d_ptr     = insn_valid && insn == OP_LOAD_POINTER;
  wire logic d_ext     = insn_valid && insn == OP_LOAD_EXTENSION;
  // Port structure, interrupt and wakeup copies
  wire logic d_pd0     = insn_valid && insn == OP_PORT_DRIVE_CFG_0;
  wire logic d_pd1     = insn_valid && insn == OP_PORT_DRIVE_CFG_1;
  wire logic d_pd2     = insn_valid && insn == OP_PORT_DRIVE_CFG_2;
  wire logic d_irq     = insn_valid && insn == OP_WRITE_IRQ_CTRL_ONE;
  wire logic d_kw0     = insn_valid && insn == OP_WRITE_KEY_WAKE_0;
  wire logic d_kw1     = insn_valid && insn == OP_WRITE_KEY_WAKE_1;
  wire logic d_kw2     = insn_valid && insn == OP_WRITE_KEY_WAKE_2;
  // LCD mode and LCD timer copies
  wire logic d_lm1     = insn_valid && insn == OP_WRITE_LCD_MODE_ONE;
  wire logic d_lm2     = insn_valid && insn == OP_WRITE_LCD_MODE_TWO;
  wire logic d_lm3     = insn_valid && insn == OP_WRITE_LCD_MODE_THREE;
  wire logic d_lct     = insn_valid && insn == OP_LOAD_LCD_CLOCK_TIMER;
  // RAM store matches the upper six bits only; the low nibble is the immediate
  wire logic d_ram     = insn_valid && insn[INSN_W-1:NIB_W] == OP_STORE_RAM_XOR_HI;
  // Clock, timer gate, prescaler, pull-up and reload copies
  wire logic d_clk     = insn_valid && insn == OP_WRITE_CLOCK_MODE_SEL;
  wire logic d_gate    = insn_valid && insn == OP_WRITE_TIMER_GATE_BIT;
  wire logic d_pre     = insn_valid && insn == OP_LOAD_PRESCALE_PAIR;
  wire logic d_pu0     = insn_valid && insn == OP_WRITE_PULLUP_CTRL_0;
  wire logic d_pu1     = insn_valid && insn == OP_WRITE_PULLUP_CTRL_1;
  wire logic d_rl1     = insn_valid && insn == OP_LOAD_FIRST_RELOAD;

  // Paired byte of second register over accumulator
  // Uses second_reg_r as held before the edge, so a copy and a pair load run back to back
  wire logic [BYTE_W-1:0] pair_byte = {second_reg_r, acc_in};

  // Immediate operand of the RAM store
  wire logic [NIB_W-1:0] imm_j = insn[NIB_W-1:0];

  // Core-facing results are combinational so they land in the same cycle
  assign acc_we     = d_bank;
  assign acc_wdata  = {{(NIB_W-BANK_W){1'b0}}, bank_in};
  assign file_we    = d_ram;
  assign file_wdata = file_in ^ imm_j;
  assign ram_we     = d_ram;
  // Address is bank, file, pointer; fitted to the parameter width on purpose
  assign ram_addr   = RAM_ADDR_W'({bank_in, file_in, ram_pointer_r});
  assign ram_wdata  = acc_in;
  // Carry passes through and no skip is ever requested by this group
  assign carry_out  = carry_in;
  assign skip_next  = 1'b0;

  // Group membership for the core sequencer
  // Tells the core that no other decoder owns this word
  assign hit = d_bank | d_second | d_lc1 | d_lc2 | d_ptr | d_ext | d_pd0 | d_pd1 | d_pd2
             | d_irq | d_kw0 | d_kw1 | d_kw2 | d_lm1 | d_lm2 | d_lm3 | d_lct | d_ram
             | d_clk | d_gate | d_pre | d_pu0 | d_pu1 | d_rl1;

  // Working registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // Cleared; the core rewrites them before use
      second_reg_r  <= NIB_RST;
      ram_pointer_r <= PTR_RST;
      extension_r   <= BYTE_RST;
    end else begin
      // Each word writes only its own target; all else holds
      if (d_second) second_reg_r <= acc_in;
      // Top accumulator bit is dropped, the pointer is only three wide
      if (d_ptr) ram_pointer_r <= acc_in[PTR_W-1:0];
      if (d_ext) extension_r <= pair_byte;
    end
  end

  // LCD control and mode registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // LCD stays blank until software programs it
      lcd_ctrl_one_r   <= NIB_RST;
      lcd_ctrl_two_r   <= NIB_RST;
      lcd_mode_one_r   <= NIB_RST;
      lcd_mode_two_r   <= NIB_RST;
      lcd_mode_three_r <= NIB_RST;
    end else begin
      // Full nibble copies
      if (d_lc1) lcd_ctrl_one_r <= acc_in;
      if (d_lc2) lcd_ctrl_two_r <= acc_in;
      if (d_lm1) lcd_mode_one_r <= acc_in;
      if (d_lm2) lcd_mode_two_r <= acc_in;
      if (d_lm3) lcd_mode_three_r <= acc_in;
    end
  end

  // Port structure, pull-up and wakeup registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // Pins come up with default drive, no pull-up and no wakeup
      port_drive_cfg_0_r <= NIB_RST;
      port_drive_cfg_1_r <= NIB_RST;
      port_drive_cfg_2_r <= NIB_RST;
      key_wake_0_r       <= NIB_RST;
      key_wake_1_r       <= NIB_RST;
      key_wake_2_r       <= NIB_RST;
      pullup_ctrl_0_r    <= NIB_RST;
      pullup_ctrl_1_r    <= NIB_RST;
    end else begin
      // Full nibble copies, no read-modify-write
      if (d_pd0) port_drive_cfg_0_r <= acc_in;
      if (d_pd1) port_drive_cfg_1_r <= acc_in;
      if (d_pd2) port_drive_cfg_2_r <= acc_in;
      if (d_kw0) key_wake_0_r <= acc_in;
      if (d_kw1) key_wake_1_r <= acc_in;
      if (d_kw2) key_wake_2_r <= acc_in;
      if (d_pu0) pullup_ctrl_0_r <= acc_in;
      if (d_pu1) pullup_ctrl_1_r <= acc_in;
    end
  end

  // Interrupt and clock control
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // Interrupts and clock selection start at their cleared codes
      irq_ctrl_one_r   <= NIB_RST;
      clock_mode_sel_r <= NIB_RST;
    end else begin
      // Full nibble copies
      if (d_irq) irq_ctrl_one_r <= acc_in;
      if (d_clk) clock_mode_sel_r <= acc_in;
    end
  end

  // Timer loads; the counters here only hold the loaded value, counting lives elsewhere
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // Timers stopped and empty
      lcd_timer_r            <= NIB_RST;
      counter_reload_value_r <= NIB_RST;
      timer_gate_r           <= 1'b0;
      prescale_count_r       <= BYTE_RST;
      prescale_reload_r      <= BYTE_RST;
      first_reload_r         <= BYTE_RST;
    end else begin
      // Counter and reload take one value, so the first period is a full one
      if (d_lct) begin
        lcd_timer_r            <= acc_in;
        counter_reload_value_r <= acc_in;
      end
      // Only the lowest bit matters; the gate is a single flag
      if (d_gate) timer_gate_r <= acc_in[0];
      // Prescaler and its reload load from the pair at once
      if (d_pre) begin
        prescale_count_r  <= pair_byte;
        prescale_reload_r <= pair_byte;
      end
      if (d_rl1) first_reload_r <= pair_byte;
    end
  end

  // Checks: registered targets are looked at one edge after the word,
  // the core strobes in the cycle of the word itself
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_BANK_ZERO_TOP: assert property (
    acc_we |-> acc_wdata[3:2] == 2'b00 && acc_wdata[1:0] == bank_in)
    else $error("bank copy result wrong");
  AST_SECOND_LOAD: assert property (d_second |=> second_reg_r == $past(acc_in))
    else $error("second register not loaded");
  AST_LCD_CTRL_ONE: assert property (d_lc1 |=> lcd_ctrl_one_r == $past(acc_in))
    else $error("lcd control one not written");
  AST_POINTER_LOW: assert property (d_ptr |=> ram_pointer_r == $past(acc_in[2:0]))
    else $error("pointer load wrong");
  AST_EXT_PAIR: assert property (
    d_ext |=> extension_r == {$past(second_reg_r), $past(acc_in)})
    else $error("extension pair wrong");
  AST_PORT_CFG2: assert property (d_pd2 |=> port_drive_cfg_2_r == $past(acc_in))
    else $error("port config two not written");
  AST_IRQ_ONE: assert property (d_irq |=> irq_ctrl_one_r == $past(acc_in))
    else $error("interrupt control not written");
  AST_WAKE0: assert property (d_kw0 |=> key_wake_0_r == $past(acc_in))
    else $error("wakeup zero not written");
  AST_LCD_MODE3: assert property (d_lm3 |=> lcd_mode_three_r == $past(acc_in))
    else $error("lcd mode three not written");
  AST_LCD_TIMER_BOTH: assert property (
    d_lct |=> lcd_timer_r == $past(acc_in) && counter_reload_value_r == $past(acc_in))
    else $error("lcd timer and reload differ");
  AST_RAM_STORE: assert property (
    d_ram |-> ram_we && file_we && ram_wdata == acc_in
              && file_wdata == (file_in ^ insn[NIB_W-1:0]))
    else $error("ram store wrong");
  AST_CLOCK_MODE: assert property (d_clk |=> clock_mode_sel_r == $past(acc_in))
    else $error("clock mode not written");
  AST_GATE_BIT: assert property (d_gate |=> timer_gate_r == $past(acc_in[0]))
    else $error("timer gate wrong");
  AST_PRESCALE: assert property (
    d_pre |=> prescale_count_r == {$past(second_reg_r), $past(acc_in)}
              && prescale_reload_r == {$past(second_reg_r), $past(acc_in)})
    else $error("prescaler load wrong");
  AST_PULLUP1: assert property (d_pu1 |=> pullup_ctrl_1_r == $past(acc_in))
    else $error("pull-up one not written");
  AST_RELOAD1: assert property (
    d_rl1 |=> first_reload_r == {$past(second_reg_r), $past(acc_in)})
    else $error("first reload wrong");
  AST_NO_SKIP: assert property (hit |-> !skip_next && carry_out == carry_in)
    else $error("carry or skip disturbed");

  // Remaining copy targets, one check each
  AST_LCD_CTRL_TWO: assert property (d_lc2 |=> lcd_ctrl_two_r == $past(acc_in))
    else $error("lcd control two not written");
  AST_PORT_CFG0: assert property (d_pd0 |=> port_drive_cfg_0_r == $past(acc_in))
    else $error("port config zero not written");
  AST_PORT_CFG1: assert property (d_pd1 |=> port_drive_cfg_1_r == $past(acc_in))
    else $error("port config one not written");
  AST_WAKE1: assert property (d_kw1 |=> key_wake_1_r == $past(acc_in))
    else $error("wakeup one not written");
  AST_WAKE2: assert property (d_kw2 |=> key_wake_2_r == $past(acc_in))
    else $error("wakeup two not written");
  AST_LCD_MODE1: assert property (d_lm1 |=> lcd_mode_one_r == $past(acc_in))
    else $error("lcd mode one not written");
  AST_LCD_MODE2: assert property (d_lm2 |=> lcd_mode_two_r == $past(acc_in))
    else $error("lcd mode two not written");
  AST_PULLUP0: assert property (d_pu0 |=> pullup_ctrl_0_r == $past(acc_in))
    else $error("pull-up zero not written");

  // Words outside the group and idle cycles leave everything alone
  AST_REFUSED: assert property (!hit |-> !acc_we && !file_we && !ram_we)
    else $error("strobe without a group word");
  AST_IDLE_HOLDS: assert property (
    !insn_valid |=> $stable(second_reg_r) && $stable(timer_gate_r)
                    && $stable(extension_r) && $stable(prescale_count_r))
    else $error("register changed on an idle cycle");
  AST_CARRY_ALWAYS: assert property (carry_out == carry_in && !skip_next)
    else $error("carry or skip disturbed outside the group");

  // Main scenarios: stores back to back, pair after copy, bank copy, pointer then store
  COV_RAM_STORE: cover property (d_ram ##1 d_ram);
  COV_PRESCALE: cover property (d_second ##1 (d_ext || d_pre));
  COV_BANK: cover property (d_bank);
  COV_PTR_THEN_RAM: cover property (d_ptr ##[1:40] d_ram);
  COV_LCD_TIMER: cover property (d_lct);

endmodule : acc_register_transfer_decode

//--- hw/acc_xfer_pkg.sv
// Package for the accumulator transfer decoder: opcodes, widths and reset values
package acc_xfer_pkg;

  // Datapath widths
  localparam int NIB_W   = 4;   // Accumulator and nibble registers
  localparam int INSN_W  = 10;  // Instruction word
  localparam int PTR_W   = 3;   // RAM pointer width
  localparam int BANK_W  = 2;   // RAM bank register width
  localparam int BYTE_W  = 8;   // Paired register width

  // Opcodes of the transfer group
  localparam logic [9:0] OP_COPY_BANK_TO_ACC     = 10'h053;
  localparam logic [9:0] OP_COPY_ACC_TO_SECOND   = 10'h00E;
  localparam logic [9:0] OP_WRITE_LCD_CTRL_ONE   = 10'h2A8;
  localparam logic [9:0] OP_WRITE_LCD_CTRL_TWO   = 10'h2A9;
  localparam logic [9:0] OP_LOAD_POINTER         = 10'h029;
  localparam logic [9:0] OP_LOAD_EXTENSION       = 10'h01A;
  localparam logic [9:0] OP_PORT_DRIVE_CFG_0     = 10'h228;
  localparam logic [9:0] OP_PORT_DRIVE_CFG_1     = 10'h229;
  localparam logic [9:0] OP_PORT_DRIVE_CFG_2     = 10'h22A;
  localparam logic [9:0] OP_WRITE_IRQ_CTRL_ONE   = 10'h217;
  localparam logic [9:0] OP_WRITE_KEY_WAKE_0     = 10'h21B;
  localparam logic [9:0] OP_WRITE_KEY_WAKE_1     = 10'h214;
  localparam logic [9:0] OP_WRITE_KEY_WAKE_2     = 10'h215;
  localparam logic [9:0] OP_WRITE_LCD_MODE_ONE   = 10'h20A;
  localparam logic [9:0] OP_WRITE_LCD_MODE_TWO   = 10'h20B;
  localparam logic [9:0] OP_WRITE_LCD_MODE_THREE = 10'h20C;
  localparam logic [9:0] OP_LOAD_LCD_CLOCK_TIMER = 10'h20D;
  localparam logic [5:0] OP_STORE_RAM_XOR_HI     = 6'h2B;  // Upper six bits, low four are j
  localparam logic [9:0] OP_WRITE_CLOCK_MODE_SEL = 10'h216;
  localparam logic [9:0] OP_WRITE_TIMER_GATE_BIT = 10'h2AA;
  localparam logic [9:0] OP_LOAD_PRESCALE_PAIR   = 10'h235;
  localparam logic [9:0] OP_WRITE_PULLUP_CTRL_0  = 10'h22D;
  localparam logic [9:0] OP_WRITE_PULLUP_CTRL_1  = 10'h22E;
  localparam logic [9:0] OP_LOAD_FIRST_RELOAD    = 10'h23F;

  // Reset values
  localparam logic [3:0] NIB_RST  = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] PTR_RST  = 3'h0;

endpackage : acc_xfer_pkg

//--- verification/insn_stream_model.sv
// Instruction stream model: the program memory word seen by the decoder each cycle
`timescale 1ns/1ps
module insn_stream_model
  import acc_xfer_pkg::*;
(
  input  wire logic              clk_sys,    // Instruction clock
  input  wire logic              rst_n,      // Async reset, active low
  input  wire logic              fetch_req,  // Bench asks for a word this cycle
  input  wire logic [INSN_W-1:0] fetch_word, // Word placed in program memory
  output logic                   insn_valid, // Word is to be executed
  output logic [INSN_W-1:0]      insn        // Word on the fetch bus
);
  logic [INSN_W-1:0] idle_pat_r; // Churning idle pattern

  // Idle bus churns every cycle; a stale word would hide a decoder that ignores valid
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idle_pat_r <= 10'h155;
    end else begin
      idle_pat_r <= ~idle_pat_r;
    end
  end

  // A whole ten-bit word per cycle, qualified by valid
  assign insn_valid = fetch_req;
  assign insn       = fetch_req ? fetch_word : idle_pat_r;
endmodule : insn_stream_model

//--- verification/acc_register_transfer_decode_tb.sv
// Self-checking bench for the accumulator transfer decoder
`timescale 1ns/1ps
module acc_register_transfer_decode_tb;
  import acc_xfer_pkg::*;
  typedef struct packed { logic [9:0] op; logic [3:0] acc; logic [7:0] exp; } row_t;
  logic       clk_sys    = 1'b0;  // 50 MHz clock
  logic       rst_n      = 1'b0;  // Reset, active low
  logic       fetch_req  = 1'b0;  // Word request to the stream model
  logic [9:0] fetch_word = 10'h000; // Word to execute
  logic [3:0] acc_in     = 4'h0;  // Accumulator
  logic [1:0] bank_in    = 2'h0;  // RAM bank
  logic [3:0] file_in    = 4'h0;  // RAM file
  logic       carry_in   = 1'b0;  // Carry flag
  wire        insn_valid;         // From stream model
  wire  [9:0] insn;               // From stream model
  int         miscompares = 0;    // Mismatch count
  int         num_checks  = 0;    // Comparison count
  // Ordinary cases: word, accumulator, expected target; 0x00E first feeds the pair loads
  row_t rows [23] = '{ {10'h00E,4'h9,8'h09}, {10'h01A,4'h3,8'h93}, {10'h235,4'h4,8'h94},
    {10'h23F,4'hC,8'h9C}, {10'h029,4'hF,8'h07}, {10'h2AA,4'hE,8'h00}, {10'h2AA,4'h5,8'h01},
    {10'h20D,4'h6,8'h06}, {10'h2A8,4'h1,8'h01}, {10'h2A9,4'h2,8'h02}, {10'h228,4'h3,8'h03},
    {10'h229,4'h4,8'h04}, {10'h22A,4'h5,8'h05}, {10'h217,4'h6,8'h06}, {10'h21B,4'h7,8'h07},
    {10'h214,4'h8,8'h08}, {10'h215,4'hA,8'h0A}, {10'h20A,4'hB,8'h0B}, {10'h20B,4'hC,8'h0C},
    {10'h20C,4'hD,8'h0D}, {10'h216,4'hE,8'h0E}, {10'h22D,4'hF,8'h0F}, {10'h22E,4'h1,8'h01} };

  // Free-running clock
  always #10 clk_sys = ~clk_sys;

  insn_stream_model stream (.clk_sys(clk_sys), .rst_n(rst_n), .fetch_req(fetch_req),
    .fetch_word(fetch_word), .insn_valid(insn_valid), .insn(insn));

  acc_register_transfer_decode #(.RAM_ADDR_W(9)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .insn_valid(insn_valid), .insn(insn),
    .acc_in(acc_in), .bank_in(bank_in), .file_in(file_in), .carry_in(carry_in),
    .acc_we(), .acc_wdata(), .file_we(), .file_wdata(), .carry_out(), .skip_next(),
    .ram_we(), .ram_addr(), .ram_wdata(), .hit(), .second_reg_r(), .ram_pointer_r(),
    .extension_r(), .lcd_ctrl_one_r(), .lcd_ctrl_two_r(), .port_drive_cfg_0_r(),
    .port_drive_cfg_1_r(), .port_drive_cfg_2_r(), .irq_ctrl_one_r(), .key_wake_0_r(),
    .key_wake_1_r(), .key_wake_2_r(), .lcd_mode_one_r(), .lcd_mode_two_r(),
    .lcd_mode_three_r(), .lcd_timer_r(), .counter_reload_value_r(), .clock_mode_sel_r(),
    .timer_gate_r(), .prescale_count_r(), .prescale_reload_r(), .pullup_ctrl_0_r(),
    .pullup_ctrl_1_r(), .first_reload_r());

  // Target register of each transfer word, zero-extended to a byte
  function automatic logic [7:0] observe(input logic [9:0] op);
    case (op)
      10'h00E: return {4'h0, dut.second_reg_r};
      10'h01A: return dut.extension_r;
      10'h235: return dut.prescale_count_r;
      10'h23F: return dut.first_reload_r;
      10'h029: return {5'h00, dut.ram_pointer_r};
      10'h2AA: return {7'h00, dut.timer_gate_r};
      10'h20D: return {4'h0, dut.lcd_timer_r};
      10'h2A8: return {4'h0, dut.lcd_ctrl_one_r};
      10'h2A9: return {4'h0, dut.lcd_ctrl_two_r};
      10'h228: return {4'h0, dut.port_drive_cfg_0_r};
      10'h229: return {4'h0, dut.port_drive_cfg_1_r};
      10'h22A: return {4'h0, dut.port_drive_cfg_2_r};
      10'h217: return {4'h0, dut.irq_ctrl_one_r};
      10'h21B: return {4'h0, dut.key_wake_0_r};
      10'h214: return {4'h0, dut.key_wake_1_r};
      10'h215: return {4'h0, dut.key_wake_2_r};
      10'h20A: return {4'h0, dut.lcd_mode_one_r};
      10'h20B: return {4'h0, dut.lcd_mode_two_r};
      10'h20C: return {4'h0, dut.lcd_mode_three_r};
      10'h216: return {4'h0, dut.clock_mode_sel_r};
      10'h22D: return {4'h0, dut.pullup_ctrl_0_r};
      10'h22E: return {4'h0, dut.pullup_ctrl_1_r};
      default: return 8'hFF;  // Bank copy, RAM store or foreign word
    endcase
  endfunction : observe

  // Compare one value, four-state exact
  task automatic check_val(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_val

  // Present one word at the falling edge; request stays up so words run back to back
  task automatic issue(input logic [9:0] op, input logic [3:0] acc);
    @(negedge clk_sys);
    fetch_req  = 1'b1;
    fetch_word = op;
    acc_in     = acc;
  endtask : issue

  // Counts, verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // Hang guard: a bounded run, overrun counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    $display("unexpected timeout at %0t", $time);
    final_report();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    foreach (rows[i]) check_val({1'b0, observe(rows[i].op)}, 9'h000);
    $display("test reset_values finished");
    foreach (rows[i]) begin
      issue(rows[i].op, rows[i].acc);
      @(posedge clk_sys);
      #1;
      check_val({1'b0, observe(rows[i].op)}, {1'b0, rows[i].exp});
    end
    check_val({1'b0, dut.prescale_reload_r}, 9'h094);
    check_val({5'h00, dut.counter_reload_value_r}, 9'h006);
    check_val({1'b0, dut.extension_r}, 9'h093);
    $display("test table_transfers finished");
    // Store with every immediate; pointer holds 7 from the table
    for (int j = 0; j < 16; j++) begin
      issue({OP_STORE_RAM_XOR_HI, 4'(j)}, 4'hA);
      file_in = 4'h1;
      bank_in = 2'h2;
      #2;
      check_val({8'h00, dut.ram_we}, 9'h001);
      check_val({5'h00, dut.ram_wdata}, 9'h00A);
      check_val({8'h00, dut.file_we}, 9'h001);
      check_val({5'h00, dut.file_wdata}, {5'h00, 4'h1 ^ 4'(j)});
      check_val(dut.ram_addr, {2'h2, 4'h1, 3'h7});
    end
    $display("test ram_store finished");
    issue(OP_COPY_BANK_TO_ACC, 4'hF);
    bank_in  = 2'h3;
    carry_in = 1'b1;
    #2;
    check_val({8'h00, dut.acc_we}, 9'h001);
    check_val({5'h00, dut.acc_wdata}, 9'h003);
    check_val({8'h00, dut.carry_out}, 9'h001);
    check_val({8'h00, dut.skip_next}, 9'h000);
    check_val({8'h00, dut.hit}, 9'h001);
    $display("test bank_copy finished");
    // Foreign word: nothing may change
    issue(10'h2A0, 4'h5);
    carry_in = 1'b0;
    #2;
    check_val({8'h00, dut.hit}, 9'h000);
    check_val({8'h00, dut.carry_out}, 9'h000);
    check_val({7'h00, dut.ram_we, dut.acc_we}, 9'h000);
    @(posedge clk_sys);
    #1;
    check_val({5'h00, dut.lcd_ctrl_one_r}, 9'h001);
    // Request dropped while the idle bus churns through a gate word
    @(negedge clk_sys);
    fetch_req = 1'b0;
    acc_in    = 4'h0;
    repeat (4) @(posedge clk_sys);
    #1;
    check_val({8'h00, dut.timer_gate_r}, 9'h001);
    $display("test refused_words finished");
    // Reset in mid-run clears, then first word one cycle after release
    @(negedge clk_sys);
    rst_n = 1'b0;
    #2;
    check_val({5'h00, dut.second_reg_r}, 9'h000);
    check_val({1'b0, dut.prescale_count_r}, 9'h000);
    @(negedge clk_sys);
    rst_n = 1'b1;
    issue(OP_COPY_ACC_TO_SECOND, 4'h5);
    @(posedge clk_sys);
    #1;
    check_val({5'h00, dut.second_reg_r}, 9'h005);
    $display("test mid_reset finished");
    final_report();
  end
endmodule : acc_register_transfer_decode_tb
